// ===== oct_timing_params.svh
/*
  timing constants for the one-cycle core instruction timing block: each
  instruction form as a packed {length in bytes, execution cycles} pair.
  assumes: included by bare name, definitions only.
*/
`ifndef OCT_TIMING_PARAMS_SVH
`define OCT_TIMING_PARAMS_SVH

// field layout of a packed timing entry: {len[1:0], cyc[2:0]}
`define OCT_LEN_MSB 4
`define OCT_LEN_LSB 3
`define OCT_CYC_MSB 2
`define OCT_CYC_LSB 0

// documented widths of the length and cycle fields
`define OCT_LEN_W 2
`define OCT_CYC_W 3

// reset value of captured opcode and timing
`define OCT_OP_RST  8'h00
`define OCT_ENT_RST 5'h00

// accumulator loads
`define OCT_T_MOV_A_RN   {2'h1, 3'h1}
`define OCT_T_MOV_A_DIR  {2'h2, 3'h2}
`define OCT_T_MOV_A_IND  {2'h1, 3'h2}
`define OCT_T_MOV_A_IMM  {2'h2, 3'h2}
// working register writes
`define OCT_T_MOV_RN_A   {2'h1, 3'h2}
`define OCT_T_MOV_RN_DIR {2'h2, 3'h4}
`define OCT_T_MOV_RN_IMM {2'h2, 3'h2}
// direct byte writes
`define OCT_T_MOV_DIR_A   {2'h2, 3'h3}
`define OCT_T_MOV_DIR_RN  {2'h2, 3'h3}
`define OCT_T_MOV_DIR_DIR {2'h3, 3'h4}
`define OCT_T_MOV_DIR_IND {2'h2, 3'h4}
`define OCT_T_MOV_DIR_IMM {2'h3, 3'h3}
// indirect ram writes
`define OCT_T_MOV_IND_A   {2'h1, 3'h3}
`define OCT_T_MOV_IND_DIR {2'h2, 3'h3}
`define OCT_T_MOV_IND_IMM {2'h2, 3'h3}
// pointer, code and auxiliary ram moves
`define OCT_T_MOV_DPTR    {2'h3, 3'h3}
`define OCT_T_MOVC        {2'h1, 3'h4}
`define OCT_T_MOVX_RD     {2'h1, 3'h3}
`define OCT_T_MOVX_WR_RI  {2'h1, 3'h4}
`define OCT_T_MOVX_WR_DP  {2'h1, 3'h3}
// stack and exchange
`define OCT_T_PUSH        {2'h2, 3'h4}
`define OCT_T_POP         {2'h2, 3'h3}
`define OCT_T_XCH_RN      {2'h1, 3'h3}
`define OCT_T_XCH_DIR     {2'h2, 3'h4}
`define OCT_T_XCH_IND     {2'h1, 3'h4}
// add, add with carry, subtract with borrow share one timing set
`define OCT_T_ARI_RN      {2'h1, 3'h2}
`define OCT_T_ARI_DIR     {2'h2, 3'h3}
`define OCT_T_ARI_IND     {2'h1, 3'h3}
`define OCT_T_ARI_IMM     {2'h2, 3'h2}
// anything outside the decoded groups runs as one byte, one cycle
`define OCT_T_OTHER       {2'h1, 3'h1}

`endif

// ===== oct_pkg.sv
/*
  types for the one-cycle core instruction timing block.
  assumes: compiled before the design modules.
*/
package oct_pkg;

  typedef enum logic [1:0] {
    oct_st_idle,
    oct_st_exec
  } oct_state_t;

  typedef enum logic [2:0] {
    oct_grp_other,
    oct_grp_move,
    oct_grp_code,
    oct_grp_aux,
    oct_grp_stack,
    oct_grp_xch,
    oct_grp_arith
  } oct_group_t;

endpackage : oct_pkg

// ===== oct_down_counter.sv
/*
  loadable down counter that stops at zero.
  assumes: one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module oct_down_counter #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // state
  output logic      [W-1:0] count_reg
);

  logic [W-1:0] count_next;

  // a load wins over counting; zero holds so a stale count never wraps
  assign count_next = load ? load_val :
                      (count_reg != '0) ? count_reg - W'(1) : count_reg;

  always_ff @(posedge clk) begin
    if (reset) count_reg <= '0;
    else       count_reg <= count_next;
  end

endmodule : oct_down_counter

// ===== oct_timing.sv
/*
  instruction length and execution timing sequencer for the data transfer
  and arithmetic groups of a one-clock-per-cycle 8-bit core.
  assumes: the fetch unit offers the first opcode byte with op_valid and
  holds it until op_ready; operand bytes are fetched on operand_req.
*/
// Function
// - load accumulator: register 1/1, direct 2/2, indirect 1/2, immediate 2/2
// - write register: from accumulator 1/2, direct 2/4, immediate 2/2
// - write direct: acc or reg 2/3, direct 3/4, indirect 2/4, immediate 3/3
// - write indirect ram takes 3 cycles; 1 byte from acc, else 2
// - load 16-bit data pointer with constant: 3 bytes, 3 cycles
// - code byte read relative to pointer or program counter: 1 byte, 4 cycles
// - auxiliary ram read into accumulator: 1 byte, 3 cycles, either address form
// - accumulator to auxiliary ram: 4 cycles 8-bit address, 3 cycles pointer
// - external ram moves unsupported; those forms target on-chip auxiliary ram
// - push direct 2 bytes 4 cycles; pop direct 2 bytes 3 cycles
// - exchange: register 1/3, direct 2/4, indirect or low nibble 1/4
// - add: register 1/2, direct 2/3, indirect 1/3, immediate 2/2
// - add with carry uses the same sizes and cycles as add
// - subtract with borrow: register 1/2, direct 2/3, indirect 1/3
// - subtract with borrow immediate: 2 bytes, 2 cycles
`timescale 1ns/1ps
`include "oct_timing_params.svh"
module oct_timing
  import oct_pkg::*;
#(
  parameter int LEN_W = `OCT_LEN_W,
  parameter int CYC_W = `OCT_CYC_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // opcode offer from the fetch unit
  input  wire logic             op_valid,
  input  wire logic [7:0]       op_byte,
  output logic                  op_ready,
  // operand byte fetch, one byte per high cycle
  output logic                  operand_req,
  // instruction retire report
  output logic                  done,
  output logic [7:0]            done_opcode,
  output logic [LEN_W-1:0]      done_len,
  output logic [CYC_W-1:0]      done_cycles,
  output oct_group_t            done_group,
  output logic                  done_aux_ram,
  output logic                  done_other,
  // status
  output logic                  busy
);

  // refuse widths too narrow for the longest form (3 bytes, 4 cycles)
  if (LEN_W < `OCT_LEN_W || CYC_W < `OCT_CYC_W) begin : g_width_check
    $error("oct_timing: LEN_W or CYC_W too narrow for the timing table");
  end

  logic [4:0]       ent;
  oct_group_t       grp;
  logic             aux_ram;
  logic [LEN_W-1:0] dec_len;
  logic [CYC_W-1:0] dec_cyc;

  // opcode decode to {len, cyc}; standard encoding, operand bytes follow opcode
  always_comb begin
    ent     = `OCT_T_OTHER;
    grp     = oct_grp_move;
    aux_ram = 1'b0;
    casez (op_byte)
      8'he8, 8'he9, 8'hea, 8'heb,
      8'hec, 8'hed, 8'hee, 8'hef: ent = `OCT_T_MOV_A_RN;
      8'he5:                      ent = `OCT_T_MOV_A_DIR;
      8'he6, 8'he7:               ent = `OCT_T_MOV_A_IND;
      8'h74:                      ent = `OCT_T_MOV_A_IMM;
      8'b1111_1???:               ent = `OCT_T_MOV_RN_A;
      8'b1010_1???:               ent = `OCT_T_MOV_RN_DIR;
      8'b0111_1???:               ent = `OCT_T_MOV_RN_IMM;
      8'hf5:                      ent = `OCT_T_MOV_DIR_A;
      8'b1000_1???:               ent = `OCT_T_MOV_DIR_RN;
      8'h85:                      ent = `OCT_T_MOV_DIR_DIR;
      8'h86, 8'h87:               ent = `OCT_T_MOV_DIR_IND;
      8'h75:                      ent = `OCT_T_MOV_DIR_IMM;
      8'hf6, 8'hf7:               ent = `OCT_T_MOV_IND_A;
      8'ha6, 8'ha7:               ent = `OCT_T_MOV_IND_DIR;
      8'h76, 8'h77:               ent = `OCT_T_MOV_IND_IMM;
      8'h90:                      ent = `OCT_T_MOV_DPTR;
      8'h93, 8'h83: begin
        ent = `OCT_T_MOVC;
        grp = oct_grp_code;
      end
      8'he0, 8'he2, 8'he3: begin
        ent     = `OCT_T_MOVX_RD;
        grp     = oct_grp_aux;
        aux_ram = 1'b1;
      end
      8'hf2, 8'hf3: begin
        ent     = `OCT_T_MOVX_WR_RI;
        grp     = oct_grp_aux;
        aux_ram = 1'b1;
      end
      8'hf0: begin
        ent     = `OCT_T_MOVX_WR_DP;
        grp     = oct_grp_aux;
        aux_ram = 1'b1;
      end
      8'hc0: begin
        ent = `OCT_T_PUSH;
        grp = oct_grp_stack;
      end
      8'hd0: begin
        ent = `OCT_T_POP;
        grp = oct_grp_stack;
      end
      8'b1100_1???: begin
        ent = `OCT_T_XCH_RN;
        grp = oct_grp_xch;
      end
      8'hc5: begin
        ent = `OCT_T_XCH_DIR;
        grp = oct_grp_xch;
      end
      8'hc6, 8'hc7, 8'hd6, 8'hd7: begin
        ent = `OCT_T_XCH_IND;
        grp = oct_grp_xch;
      end
      // add 2x, add with carry 3x, subtract with borrow 9x share the low nibble
      8'b0010_1???, 8'b0011_1???, 8'b1001_1???: begin
        ent = `OCT_T_ARI_RN;
        grp = oct_grp_arith;
      end
      8'h25, 8'h35, 8'h95: begin
        ent = `OCT_T_ARI_DIR;
        grp = oct_grp_arith;
      end
      8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97: begin
        ent = `OCT_T_ARI_IND;
        grp = oct_grp_arith;
      end
      8'h24, 8'h34, 8'h94: begin
        ent = `OCT_T_ARI_IMM;
        grp = oct_grp_arith;
      end
      default: begin
        ent = `OCT_T_OTHER;
        grp = oct_grp_other;
      end
    endcase
  end

  assign dec_len = LEN_W'(ent[`OCT_LEN_MSB:`OCT_LEN_LSB]);
  assign dec_cyc = CYC_W'(ent[`OCT_CYC_MSB:`OCT_CYC_LSB]);

  oct_state_t       state_reg;
  oct_state_t       state_next;
  logic             ready_reg;
  logic             ready_next;
  logic             req_reg;
  logic             accept;
  logic             one_cycle;
  logic             last_exec;
  logic             finish;
  logic [CYC_W-1:0] cyc_cnt;
  logic [LEN_W-1:0] byte_cnt;
  logic [CYC_W-1:0] cyc_load;
  logic [LEN_W-1:0] byte_load;
  logic [LEN_W-1:0] byte_after;

  // an opcode is only taken while idle, so a running instruction always
  // spends its full count before the next one starts
  assign accept     = op_valid & ready_reg;
  assign one_cycle  = (dec_cyc == CYC_W'(1));
  assign last_exec  = (state_reg == oct_st_exec) && (cyc_cnt == CYC_W'(1));
  assign finish     = (accept & one_cycle) | last_exec;
  assign cyc_load   = dec_cyc - CYC_W'(1);
  assign byte_load  = dec_len - LEN_W'(1);
  assign byte_after = accept ? byte_load :
                      (byte_cnt != '0) ? byte_cnt - LEN_W'(1) : byte_cnt;

  // remaining execution cycles after the accept cycle, one per clock
  oct_down_counter #(
    .W (CYC_W)
  ) u_cycle_count (
    .clk       (clk),
    .reset     (reset),
    .load      (accept),
    .load_val  (cyc_load),
    .count_reg (cyc_cnt)
  );

  // remaining operand bytes to fetch; the table keeps length within cycles
  oct_down_counter #(
    .W (LEN_W)
  ) u_byte_count (
    .clk       (clk),
    .reset     (reset),
    .load      (accept),
    .load_val  (byte_load),
    .count_reg (byte_cnt)
  );

  // state and ready sequencing
  always_comb begin
    state_next = state_reg;
    ready_next = ready_reg;
    case (state_reg)
      oct_st_idle: begin
        if (accept && !one_cycle) begin
          state_next = oct_st_exec;
          ready_next = 1'b0;
        end
      end
      oct_st_exec: begin
        if (last_exec) begin
          state_next = oct_st_idle;
          ready_next = 1'b1;
        end
      end
      default: begin
        state_next = oct_st_idle;
        ready_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= oct_st_idle;
      ready_reg <= 1'b1;
      req_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      req_reg   <= (byte_after != '0);
    end
  end

  logic [7:0]       cur_op;
  logic [4:0]       cur_ent;
  oct_group_t       cur_grp;
  logic             cur_aux;
  logic [7:0]       rep_op;
  logic [4:0]       rep_ent;
  oct_group_t       rep_grp;
  logic             rep_aux;
  logic             done_reg;
  logic [7:0]       dop_reg;
  logic [4:0]       dent_reg;
  oct_group_t       dgrp_reg;
  logic             daux_reg;

  // a one-cycle form retires on its accept edge, so report the live decode
  assign rep_op  = accept ? op_byte : cur_op;
  assign rep_ent = accept ? ent     : cur_ent;
  assign rep_grp = accept ? grp     : cur_grp;
  assign rep_aux = accept ? aux_ram : cur_aux;

  // capture decode on accept, publish it on the retire edge
  always_ff @(posedge clk) begin
    if (reset) begin
      cur_op   <= `OCT_OP_RST;
      cur_ent  <= `OCT_ENT_RST;
      cur_grp  <= oct_grp_other;
      cur_aux  <= 1'b0;
      done_reg <= 1'b0;
      dop_reg  <= `OCT_OP_RST;
      dent_reg <= `OCT_ENT_RST;
      dgrp_reg <= oct_grp_other;
      daux_reg <= 1'b0;
    end else begin
      cur_op   <= rep_op;
      cur_ent  <= rep_ent;
      cur_grp  <= rep_grp;
      cur_aux  <= rep_aux;
      done_reg <= finish;
      if (finish) begin
        dop_reg  <= rep_op;
        dent_reg <= rep_ent;
        dgrp_reg <= rep_grp;
        daux_reg <= rep_aux;
      end
    end
  end

  // every output is a flop or a compare on one; no external ram strobe exists at all
  assign op_ready     = ready_reg;
  assign operand_req  = req_reg;
  assign done         = done_reg;
  assign done_opcode  = dop_reg;
  assign done_len     = LEN_W'(dent_reg[`OCT_LEN_MSB:`OCT_LEN_LSB]);
  assign done_cycles  = CYC_W'(dent_reg[`OCT_CYC_MSB:`OCT_CYC_LSB]);
  assign done_group   = dgrp_reg;
  assign done_aux_ram = daux_reg;
  assign done_other   = (dgrp_reg == oct_grp_other);
  assign busy         = (state_reg == oct_st_exec);

endmodule : oct_timing

// ===== oct_timing_asserts.sv
/*
  concurrent checks on the port timing of oct_timing.
  assumes: bound to every oct_timing instance; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module oct_timing_asserts
  import oct_pkg::*;
#(
  parameter int LEN_W = 2,
  parameter int CYC_W = 3
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             reset,
  // opcode handshake
  input wire logic             op_valid,
  input wire logic [7:0]       op_byte,
  input wire logic             op_ready,
  input wire logic             operand_req,
  // retire report
  input wire logic             done,
  input wire logic [7:0]       done_opcode,
  input wire logic [LEN_W-1:0] done_len,
  input wire logic [CYC_W-1:0] done_cycles,
  input wire oct_group_t       done_group,
  input wire logic             done_aux_ram,
  input wire logic             done_other,
  input wire logic             busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // cycles and operand fetches seen since the last accepted opcode
  logic [CYC_W-1:0] run_reg;
  logic [LEN_W-1:0] opr_reg;
  logic [7:0]       op_reg;
  wire              accept = op_valid && op_ready;

  // run count saturates so a retire that never comes cannot wrap into a match
  always_ff @(posedge clk) begin
    if (reset || accept) begin
      run_reg <= CYC_W'(accept && !reset);
      opr_reg <= '0;
      op_reg  <= reset ? 8'h00 : op_byte;
    end else begin
      run_reg <= (&run_reg) ? run_reg : run_reg + CYC_W'(1);
      opr_reg <= opr_reg + LEN_W'(operand_req);
    end
  end

  AST_CYCLES_MATCH: assert property (done |-> run_reg == done_cycles)
    else $error("retire came after the wrong number of cycles");
  AST_OPERANDS_MATCH: assert property (done |-> opr_reg + LEN_W'(1) == done_len)
    else $error("operand fetch count differs from the length");
  AST_DONE_BOUNDED: assert property (accept |-> ##[1:4] done)
    else $error("no retire within four cycles of an accept");
  AST_BUSY_BLOCKS: assert property (busy |-> !op_ready)
    else $error("ready while an instruction still runs");
  AST_FETCH_IN_RUN: assert property (operand_req |-> busy && !done)
    else $error("operand fetch outside a running instruction");
  AST_READY_AT_DONE: assert property (done |-> op_ready && !busy)
    else $error("not ready in the retire cycle");
  AST_AUX_ONLY: assert property (done |-> done_aux_ram == (done_group == oct_grp_aux))
    else $error("auxiliary ram flag and group disagree");
  AST_AUX_TIMING: assert property (done && done_aux_ram |->
    done_len == 2'h1 && done_cycles inside {3'h3, 3'h4})
    else $error("auxiliary ram move with wrong timing");
  AST_OTHER_SHORT: assert property (done && done_other |-> done_len == 2'h1 && done_cycles == 3'h1)
    else $error("unlisted opcode not one byte one cycle");
  AST_OPCODE_ECHO: assert property (done |-> done_opcode == op_reg)
    else $error("retired opcode is not the accepted one");
  AST_RESULT_HELD: assert property (!done && !$past(reset) |-> $stable(done_opcode) && $stable(done_len))
    else $error("retire report changed without a retire");
endmodule : oct_timing_asserts

bind oct_timing oct_timing_asserts #(.LEN_W(LEN_W), .CYC_W(CYC_W)) u_asserts (
  .clk(clk), .reset(reset), .op_valid(op_valid), .op_byte(op_byte), .op_ready(op_ready),
  .operand_req(operand_req), .done(done), .done_opcode(done_opcode), .done_len(done_len),
  .done_cycles(done_cycles), .done_group(done_group), .done_aux_ram(done_aux_ram),
  .done_other(done_other), .busy(busy)
);

// ===== oct_fetch_model.sv
/*
  fetch side model: offers opcode bytes and holds each one until taken.
  assumes: its task is called just after a rising clock edge.
*/
`timescale 1ns/1ps
module oct_fetch_model (
  // clock
  input wire logic   clk,
  // handshake with the timing block
  input wire logic   op_ready,
  output logic       op_valid,
  output logic [7:0] op_byte
);
  initial begin
    op_valid = 1'b0;
    op_byte  = 8'hff;
  end

  // ready is read before each edge; a released byte shows its inverse so stale data never looks valid
  task automatic offer(input logic [7:0] op, input bit last, output bit stuck);
    bit ok;
    int n;
    n = 0;
    op_valid <= 1'b1;
    op_byte  <= op;
    do begin
      ok = op_ready;
      @(posedge clk);
      #1;
      n++;
    end while (!ok && n < 16);
    stuck = !ok;
    if (last) begin
      op_valid <= 1'b0;
      op_byte  <= ~op;
    end
  endtask : offer
endmodule : oct_fetch_model

// ===== tb_oct_timing.sv
/*
  self-checking bench for oct_timing: opcodes go in through the fetch model,
  every retire is checked for length, cycle count, group and flags.
  assumes: package, design, model and checker compiled before it.
*/
`timescale 1ns/1ps
module tb_oct_timing
  import oct_pkg::*;
;
  // clock, reset and design wires
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       op_valid, op_ready, operand_req, done, done_aux_ram, done_other, busy;
  logic [7:0] op_byte, done_opcode, acc_op, e;
  logic [1:0] done_len;
  logic [2:0] done_cycles;
  oct_group_t done_group;
  int         fails = 0, checked = 0, ncyc = 0, acc_n = 0, nreq = 0, ndone = 0;
  bit         inflight = 1'b0;

  always #2 clk = ~clk;

  oct_timing uut (
    .clk(clk), .reset(reset), .op_valid(op_valid), .op_byte(op_byte), .op_ready(op_ready),
    .operand_req(operand_req), .done(done), .done_opcode(done_opcode), .done_len(done_len),
    .done_cycles(done_cycles), .done_group(done_group), .done_aux_ram(done_aux_ram),
    .done_other(done_other), .busy(busy)
  );
  oct_fetch_model fetch (.clk(clk), .op_ready(op_ready), .op_valid(op_valid), .op_byte(op_byte));

  // packs {group, bytes, cycles} of one expected row
  function automatic logic [7:0] row(input int g, input int l, input int c);
    return {3'(g), 2'(l), 3'(c)};
  endfunction : row

  // expected timing of every opcode value
  function automatic logic [7:0] expect_of(input logic [7:0] op);
    casez (op)
      8'b11101???:                              return row(1, 1, 1);
      8'he5, 8'h74, 8'b01111???:                return row(1, 2, 2);
      8'b1110011?, 8'b11111???:                 return row(1, 1, 2);
      8'b10101???, 8'b1000011?:                 return row(1, 2, 4);
      8'hf5, 8'b10001???, 8'b1010011?, 8'b0111011?: return row(1, 2, 3);
      8'h85:                                    return row(1, 3, 4);
      8'h75, 8'h90:                             return row(1, 3, 3);
      8'b1111011?:                              return row(1, 1, 3);
      8'h83, 8'h93:                             return row(2, 1, 4);
      8'he0, 8'hf0, 8'b1110001?:                return row(3, 1, 3);
      8'b1111001?:                              return row(3, 1, 4);
      8'hc0:                                    return row(4, 2, 4);
      8'hd0:                                    return row(4, 2, 3);
      8'b11001???:                              return row(5, 1, 3);
      8'hc5:                                    return row(5, 2, 4);
      8'b110?011?:                              return row(5, 1, 4);
      8'b001?1???, 8'b10011???:                 return row(6, 1, 2);
      8'h24, 8'h34, 8'h94:                      return row(6, 2, 2);
      8'h25, 8'h35, 8'h95:                      return row(6, 2, 3);
      8'b001?011?, 8'b1001011?:                 return row(6, 1, 3);
      default:                                  return row(0, 1, 1);
    endcase
  endfunction : expect_of

  // count a comparison and report a mismatch at once
  task automatic chk(input bit ok, input string what);
    checked++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk

  // retire monitor on the falling edge, where every output has settled
  always @(negedge clk) begin
    ncyc++;
    if (reset) begin
      inflight = 1'b0;
    end else begin
      nreq += (operand_req === 1'b1);
      if (done === 1'b1) begin
        e = expect_of(acc_op);
        ndone++;
        chk(inflight, "retire without an accepted opcode");
        chk(done_opcode === acc_op, "retired opcode");
        chk(done_len === e[4:3] && nreq == e[4:3] - 1, "length or operand fetches");
        chk(done_cycles === e[2:0] && ncyc - acc_n == e[2:0], "cycle count");
        chk(done_group === oct_group_t'(e[7:5]), "instruction group");
        chk(done_aux_ram === (e[7:5] == 3'h3) && done_other === (e[7:5] == 3'h0), "flags");
        inflight = 1'b0;
      end
      if (op_valid === 1'b1 && op_ready === 1'b1) begin
        acc_op = op_byte;
        acc_n = ncyc;
        nreq = 0;
        inflight = 1'b1;
      end
    end
  end

  // one opcode through the model; a handshake that hangs ends the run
  task automatic send(input logic [7:0] op, input bit last);
    bit stuck;
    fetch.offer(op, last, stuck);
    if (stuck) begin
      chk(1'b0, "opcode never taken");
      end_sim();
    end
  endtask : send

  // bounded wait until n instructions have retired in all
  task automatic wait_retired(input int n);
    int k;
    k = 0;
    while (ndone < n && k < 8) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(ndone == n, "retire count");
    // a retire that never came is a hang: close the run here
    if (ndone < n) begin
      end_sim();
    end
  endtask : wait_retired

  // idle outputs as held by reset
  task automatic check_idle(input string when_s);
    chk(op_ready === 1'b1 && busy === 1'b0 && operand_req === 1'b0 && done === 1'b0, when_s);
    chk(done_len === 2'h0 && done_cycles === 3'h0 && done_other === 1'b1, when_s);
  endtask : check_idle

  // reset values after the power-up reset
  task automatic test_power_up();
    repeat (16) @(posedge clk);
    #1;
    check_idle("power-up reset values");
    reset <= 1'b0;
    $display("test power_up done");
  endtask : test_power_up

  // all 256 opcodes back to back; valid stays high so offers during a run must be ignored
  task automatic test_every_form();
    int base;
    base = ndone;
    for (int i = 0; i < 256; i++) begin
      send(8'(i), i == 255);
    end
    wait_retired(base + 256);
    $display("test every_form done");
  endtask : test_every_form

  // single opcodes with idle gaps: longest form, aux write, exchange, an unlisted code
  task automatic test_spaced();
    logic [7:0] ops [4] = '{8'h85, 8'hf2, 8'hd6, 8'ha5};
    int base;
    base = ndone;
    for (int i = 0; i < 4; i++) begin
      send(ops[i], 1'b1);
      wait_retired(base + i + 1);
      @(posedge clk);
      #1;
    end
    $display("test spaced done");
  endtask : test_spaced

  // reset in mid instruction drops it; the next opcode runs normally
  task automatic test_reset_midway();
    int base;
    base = ndone;
    send(8'h85, 1'b1);
    @(posedge clk);
    #1;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_idle("reset in mid run");
    reset <= 1'b0;
    send(8'he8, 1'b1);
    wait_retired(base + 1);
    $display("test reset_midway done");
  endtask : test_reset_midway

  // verdict and end of the run
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    test_power_up();
    test_every_form();
    test_spaced();
    test_reset_midway();
    end_sim();
  end
endmodule : tb_oct_timing
